// ===== psta_pkg.sv
// constants for the program space table access datapath
package psta_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned PROG_W      = 24;
  localparam int unsigned EA_W        = 16;
  localparam int unsigned PAGE_W      = 8;
  localparam int unsigned ADDR_W      = PAGE_W + EA_W;
  localparam int unsigned CFG_BIT     = 7;
  localparam int unsigned HI_LSB      = 16;
  localparam logic [7:0]  PAGE_RST    = 8'h00;
  localparam logic [7:0]  PHANTOM     = 8'h00;
  localparam logic [1:0]  WORD_STEP   = 2'h2;
  localparam int unsigned NLANES      = 3;
  localparam int unsigned LO_IDX      = 0;
  localparam int unsigned MID_IDX     = 1;
  localparam int unsigned UP_IDX      = 2;
  localparam logic [2:0]  LANE_NONE   = 3'h0;
  localparam logic [2:0]  LANE_LO     = 3'h1;
  localparam logic [2:0]  LANE_MID    = 3'h2;
  localparam logic [2:0]  LANE_WORD   = 3'h3;
  localparam logic [2:0]  LANE_UP     = 3'h4;

  typedef enum logic [3:0] {
    PSTA_OP_RDL = 4'h1,
    PSTA_OP_RDH = 4'h2,
    PSTA_OP_WTL = 4'h4,
    PSTA_OP_WTH = 4'h8
  } psta_op_e;

  typedef enum logic [2:0] {
    PSTA_IDLE = 3'h1,
    PSTA_WAIT = 3'h2,
    PSTA_DONE = 3'h4
  } psta_state_e;
endpackage : psta_pkg

// ===== psta_table_access.sv
// table read and write datapath between cpu core and program flash
`timescale 1ns/10ps
module psta_table_access (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  page_wr,
  input  wire logic [7:0]            page_wdata,
  output logic      [7:0]            table_page_select,
  input  wire logic                  op_valid,
  output logic                       op_ready,
  input  wire logic [3:0]            op_code,
  input  wire logic                  op_byte,
  input  wire logic [15:0]           op_ea,
  input  wire logic [15:0]           op_wdata,
  output logic                       rsp_valid,
  output logic      [15:0]           rsp_rdata,
  output logic                       mem_req,
  output logic                       mem_we,
  output logic                       mem_cfg,
  output logic      [23:0]           mem_addr,
  output logic      [2:0]            mem_lane_en,
  output logic      [23:0]           mem_wdata,
  input  wire logic                  mem_ack,
  input  wire logic [23:0]           mem_rdata
);
  psta_pkg::psta_state_e state_ff;
  psta_pkg::psta_state_e nxt_state;
  logic [7:0]  page_ff;
  logic [3:0]  op_ff;
  logic        byte_ff;
  logic        bsel_ff;
  logic [23:0] addr_ff;
  logic [23:0] wdata_ff;
  logic [2:0]  lane_ff;
  logic        we_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [7:0]  lo_byte;
  logic [7:0]  hi_byte;
  logic [7:0]  up_byte;
  logic [2:0]  nxt_lane;
  logic [23:0] nxt_wdata;
  logic        take;
  logic        is_high;
  logic        is_rdh;
  logic        is_wtl;
  logic        is_wth;
  logic        is_write;
  logic        acked;
  logic        in_idle;
  logic        in_wait;
  logic [7:0]  rd_byte [psta_pkg::NLANES];
  logic [7:0]  wr_src  [psta_pkg::NLANES];

  // state decodes
  assign in_idle  = (state_ff == psta_pkg::PSTA_IDLE);
  assign in_wait  = (state_ff == psta_pkg::PSTA_WAIT);
  assign take     = op_valid && in_idle;
  assign op_ready = in_idle;
  assign acked    = in_wait && mem_ack;

  // decoded op kinds
  assign is_rdh   = (op_code == psta_pkg::PSTA_OP_RDH);
  assign is_wtl   = (op_code == psta_pkg::PSTA_OP_WTL);
  assign is_wth   = (op_code == psta_pkg::PSTA_OP_WTH);
  assign is_high  = is_rdh || is_wth;
  assign is_write = is_wtl || is_wth;

  // page register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_ff <= psta_pkg::PAGE_RST;
    end else if (page_wr) begin
      page_ff <= page_wdata;
    end
  end
  assign table_page_select = page_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      psta_pkg::PSTA_IDLE: begin
        if (op_valid) begin
          nxt_state = psta_pkg::PSTA_WAIT;
        end
      end
      psta_pkg::PSTA_WAIT: begin
        if (mem_ack) begin
          nxt_state = psta_pkg::PSTA_DONE;
        end
      end
      psta_pkg::PSTA_DONE: begin
        nxt_state = psta_pkg::PSTA_IDLE;
      end
      default: begin
        nxt_state = psta_pkg::PSTA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= psta_pkg::PSTA_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // byte lane selection per op
  always_comb begin
    nxt_lane = psta_pkg::LANE_NONE;
    if (is_high) begin
      // upper byte only via high ops
      if (op_byte && op_ea[0]) begin
        nxt_lane = psta_pkg::LANE_NONE;
      end else begin
        nxt_lane = psta_pkg::LANE_UP;
      end
    end else if (op_byte) begin
      if (op_ea[0]) begin
        nxt_lane = psta_pkg::LANE_MID;
      end else begin
        nxt_lane = psta_pkg::LANE_LO;
      end
    end else begin
      // low ops reach least word space
      nxt_lane = psta_pkg::LANE_WORD;
    end
  end

  // write byte source per lane
  assign wr_src[psta_pkg::LO_IDX]  = op_wdata[psta_pkg::BYTE_W-1:0];
  assign wr_src[psta_pkg::MID_IDX] = op_byte ? op_wdata[psta_pkg::BYTE_W-1:0]
                                             : op_wdata[psta_pkg::DATA_W-1:psta_pkg::BYTE_W];
  // upper lane fed from low data byte
  assign wr_src[psta_pkg::UP_IDX]  = op_wdata[psta_pkg::BYTE_W-1:0];

  // one pass per program lane
  genvar gi;
  for (gi = 0; gi < psta_pkg::NLANES; gi++) begin : g_lane
    // idle lanes carry zero
    assign nxt_wdata[gi*psta_pkg::BYTE_W +: psta_pkg::BYTE_W] = nxt_lane[gi] ? wr_src[gi] : '0;
    assign rd_byte[gi] = mem_rdata[gi*psta_pkg::BYTE_W +: psta_pkg::BYTE_W];
  end

  // captured op kind
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_ff <= '0;
    end else if (take) begin
      op_ff <= op_code;
    end
  end

  // byte or word mode per op
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      byte_ff <= 1'b0;
    end else if (take) begin
      byte_ff <= op_byte;
    end
  end

  // byte select from ea bit 0
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bsel_ff <= 1'b0;
    end else if (take) begin
      bsel_ff <= op_ea[0];
    end
  end

  // word address in steps of two
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= '0;
    end else if (take) begin
      addr_ff <= {page_ff, op_ea[psta_pkg::EA_W-1:1], 1'b0};
    end
  end

  // captured write data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdata_ff <= '0;
    end else if (take) begin
      wdata_ff <= nxt_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_ff <= psta_pkg::LANE_NONE;
    end else if (take) begin
      lane_ff <= nxt_lane;
    end
  end

  // write direction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      we_ff <= 1'b0;
    end else if (take) begin
      we_ff <= is_write;
    end
  end

  // request level while waiting for flash
  assign mem_req     = in_wait;
  assign mem_we      = we_ff;
  assign mem_addr    = addr_ff;
  assign mem_lane_en = lane_ff;
  assign mem_wdata   = wdata_ff;
  assign mem_cfg     = addr_ff[psta_pkg::ADDR_W-1];

  assign lo_byte = rd_byte[psta_pkg::LO_IDX];
  assign hi_byte = rd_byte[psta_pkg::MID_IDX];
  assign up_byte = rd_byte[psta_pkg::UP_IDX];

  // read data formatting
  always_comb begin
    nxt_rdata = '0;
    unique case (op_ff)
      psta_pkg::PSTA_OP_RDL: begin
        if (!byte_ff) begin
          nxt_rdata = {hi_byte, lo_byte};
        end else if (bsel_ff) begin
          nxt_rdata = {8'h00, hi_byte};
        end else begin
          nxt_rdata = {8'h00, lo_byte};
        end
      end
      psta_pkg::PSTA_OP_RDH: begin
        if (!byte_ff) begin
          nxt_rdata = {psta_pkg::PHANTOM, up_byte};
        end else if (bsel_ff) begin
          nxt_rdata = {8'h00, psta_pkg::PHANTOM};
        end else begin
          nxt_rdata = {8'h00, up_byte};
        end
      end
      default: begin
        // writes return no data
        nxt_rdata = '0;
      end
    endcase
  end

  // completion pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= acked;
    end
  end

  // read result holds until next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else if (acked && !we_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rsp_rdata = rdata_ff;
endmodule : psta_table_access

// ===== psta_assertions.sv
// checker for the table access datapath
`timescale 1ns/10ps
module psta_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic [3:0]  op_code,
  input wire logic        op_byte,
  input wire logic [15:0] op_ea,
  input wire logic [7:0]  table_page_select,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_cfg,
  input wire logic [23:0] mem_addr,
  input wire logic [2:0]  mem_lane_en,
  input wire logic        mem_ack,
  input wire logic [23:0] mem_rdata
);
  logic [3:0]  code_q;
  logic        byte_q;
  logic [23:0] addr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk) if (op_valid && op_ready) {code_q, byte_q, addr_q} <= {op_code, op_byte, table_page_select, op_ea[15:1], 1'b0};
  a_take_req: assert property (op_valid && op_ready |=> mem_req) else $error("no request");
  a_ack_rsp: assert property (mem_req && mem_ack |=> rsp_valid && !mem_req) else $error("no response");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("long response");
  a_addr_even: assert property (mem_req |-> !mem_addr[0]) else $error("odd address");
  a_cfg_space: assert property (mem_req |-> mem_cfg == mem_addr[23]) else $error("bad space");
  a_addr_page: assert property ($rose(mem_req) |-> mem_addr == addr_q) else $error("bad address");
  a_high_zero: assert property (rsp_valid && code_q == 4'h2 |-> rsp_rdata[15:8] == 8'h00) else $error("phantom");
  a_low_word: assert property (mem_req && mem_ack && !mem_we && code_q == 4'h1 && !byte_q |=> rsp_rdata == 16'($past(mem_rdata))) else $error("low word");
  a_low_lanes: assert property (mem_req && code_q == 4'h4 |-> !mem_lane_en[2]) else $error("upper lane");
  cover property (rsp_valid && code_q == 4'h2);
  cover property (mem_req && mem_cfg);
  cover property (mem_we && mem_ack);
  cover property (mem_req && mem_we && mem_lane_en == 3'h0);
endmodule : psta_chk
bind psta_table_access psta_chk i_chk (.*);

// ===== psta_flash_model.sv
// behavioural program flash
`timescale 1ns/10ps
module psta_flash_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  dly,
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  output logic             mem_ack,
  output logic      [23:0] mem_rdata
);
  logic [1:0] wait_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) wait_ff <= 2'h0;
    else wait_ff <= (mem_req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
  end
  assign mem_ack = mem_req && (wait_ff == dly);
  // word pattern, inverted while not answering
  assign mem_rdata = {mem_addr[7:0] ^ mem_addr[23:16], mem_addr[15:0] ^ 16'ha55a} ^ {24{!mem_ack}};
endmodule : psta_flash_model

// ===== psta_tb.sv
// testbench for the table access datapath
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  logic        clk = 1'b0, nrst = 1'b0, page_wr = 1'b0, op_valid = 1'b0, op_byte = 1'b0;
  logic [7:0]  page_wdata = 8'h00, page = 8'h00;
  logic [3:0]  op_code = 4'h1;
  logic [15:0] op_ea = 16'h0000, op_wdata = 16'h0000, rsp_rdata;
  logic [1:0]  dly = 2'h0;
  logic        op_ready, rsp_valid, mem_req, mem_we, mem_cfg, mem_ack;
  logic [23:0] mem_addr, mem_wdata, mem_rdata, w;
  logic [7:0]  table_page_select;
  logic [2:0]  mem_lane_en, seen_lane;
  logic [23:0] seen_addr, seen_wdata;
  logic        seen_we, seen_cfg;
  int          err_total = 0, n_checks = 0, cyc = 0;
  psta_table_access i_dut (.*);
  psta_flash_model i_flash (.*);
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (mem_req && mem_ack)
    {seen_we, seen_cfg, seen_lane, seen_addr, seen_wdata} <= {mem_we, mem_cfg, mem_lane_en, mem_addr, mem_wdata};
  function automatic logic [23:0] fw(input logic [15:0] ea);
    logic [23:0] a;
    a = {page, ea[15:1], 1'b0};
    return {a[7:0] ^ a[23:16], a[15:0] ^ 16'ha55a};
  endfunction : fw
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic run_op(input logic [3:0] c, input logic b, input logic [15:0] ea);
    @(posedge clk);
    {op_valid, op_code, op_byte, op_ea, op_wdata} <= {1'b1, c, b, ea, ~ea};
    do @(posedge clk); while (!op_ready);
    op_valid <= 1'b0;
    do @(posedge clk); while (!rsp_valid);
    w = fw(ea);
  endtask : run_op
  task automatic set_page(input logic [7:0] p);
    @(posedge clk);
    {page_wr, page_wdata, page} <= {1'b1, p, p};
    @(posedge clk);
    page_wr <= 1'b0;
    @(posedge clk);
    `CHK(table_page_select, p)
  endtask : set_page
  task automatic t_low_reads();
    set_page(8'h12);
    run_op(4'h1, 1'b0, 16'h0104);
    `CHK(rsp_rdata, w[15:0])
    `CHK({seen_we, seen_cfg, seen_lane}, 5'h03)
    `CHK(seen_addr, 24'h120104)
    run_op(4'h1, 1'b1, 16'h0106);
    `CHK(rsp_rdata, {8'h00, w[7:0]})
    run_op(4'h1, 1'b1, 16'h0107);
    `CHK(rsp_rdata, {8'h00, w[15:8]})
    `CHK(seen_addr, 24'h120106)
  endtask : t_low_reads
  task automatic t_high_reads();
    dly <= 2'h2;
    set_page(8'h93);
    run_op(4'h2, 1'b0, 16'hfffe);
    `CHK(rsp_rdata, {8'h00, w[23:16]})
    `CHK({seen_cfg, seen_lane}, 4'hc)
    `CHK(seen_addr, 24'h93fffe)
    run_op(4'h2, 1'b1, 16'hfffc);
    `CHK(rsp_rdata, {8'h00, w[23:16]})
    run_op(4'h2, 1'b1, 16'hfffd);
    `CHK(rsp_rdata, 16'h0000)
  endtask : t_high_reads
  task automatic t_writes();
    dly <= 2'h1;
    run_op(4'h4, 1'b0, 16'h0020);
    `CHK({seen_we, seen_lane, seen_wdata}, 28'hb00ffdf)
    run_op(4'h4, 1'b1, 16'h0023);
    `CHK({seen_we, seen_lane, seen_wdata}, 28'ha00dc00)
    run_op(4'h8, 1'b1, 16'h0021);
    `CHK({seen_we, seen_lane, seen_wdata}, 28'h8000000)
    run_op(4'h8, 1'b0, 16'h0022);
    `CHK({seen_we, seen_lane, seen_wdata}, 28'hcdd0000)
    `CHK(rsp_rdata[7:0], 8'h00)
  endtask : t_writes
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_low_reads();
    t_high_reads();
    t_writes();
    report_and_stop();
  end
endmodule : testbench
